// *** hw/sbic_top.v ***
// Purpose: register set and 8-bit shift engine of the clocked serial mode
// Assumes: plain register port, read data one cycle after the read strobe
// Notes:   serial clock idles high; tx shifts on falling, rx samples on rising
// What this block does
// RL1 - enable bit 7 must be set first
// RL2 - disabled: only enable register keeps clocking
// RL3 - disable keeps all programmed register settings
// RL4 - start bit 7: 1 starts, 0 stops
// RL5 - termination bit 6 aborts transfer at once
// RL6 - mode field: tx, reserved, tx/rx, rx
// RL7 - clock select field picks shift clock rate
// RL8 - clock bit0 reads 1 until serial mode
// RL9 - software stops and terminates before reprogramming
// RL10 - data buffer: separate write and read storage
// RL11 - software avoids read-modify-write on buffer
// RL12 - mode write shares address with status read
// RL13 - operating mode: port, serial, i2c, reserved
// RL14 - software keeps mode during a session
// RL15 - status bit3 transfer, bit2 shift active
// RL16 - clock code 111 uses external clock pin
// RL17 - buffer moves to shifter, lsb first out
// RL18 - buffer move raises buffer-empty pulse
// RL19 - constant bits read fixed, ignore writes
// RL20 - software avoids reserved mode codes
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "sbic_consts.vh"
module sbic_top #(
  parameter DIV_W = 10  // width of the internal clock divider
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output wire [31:0] rdata,
  input  wire        sck_in,
  output wire        sck_out,
  output wire        sck_oe,
  output wire        sdo,
  input  wire        sdi,
  output wire        buffer_empty_irq
);
  // one-hot engine states
  localparam ST_IDLE  = 4'b0001;  // no transfer
  localparam ST_LOAD  = 4'b0010;  // waiting for buffer byte
  localparam ST_SHIFT = 4'b0100;  // eight bits moving
  localparam ST_WAIT  = 4'b1000;  // byte done, auto wait

  // register state
  reg        interface_enable_ff;  // enable bit
  reg        transfer_start_ff;    // start/stop
  reg        forced_termination_ff;// abort
  reg [1:0]  transfer_mode_sel_ff; // tx / txrx / rx
  reg [2:0]  clk_sel_ff;           // serial clock select
  reg [1:0]  operating_mode_sel_ff;// port / serial / i2c
  reg        sio_seen_ff;          // serial mode selected once
  reg [7:0]  tx_buf_ff;            // write side of buffer
  reg        tx_full_ff;           // write side holds a byte
  reg [7:0]  rx_buf_ff;            // read side of buffer
  reg [31:0] rdata_ff;             // read answer
  // engine state
  reg [3:0]  state_ff;
  reg [7:0]  shreg_ff;             // shift register
  reg [2:0]  bitcnt_ff;            // bits done in this byte
  reg        sck_ff;               // internal serial clock level
  reg        sdo_ff;               // data out, holds last bit
  reg        irq_ff;               // buffer-empty pulse
  reg        sck_oe_ff;            // clock pin driver enable
  reg [DIV_W-1:0] div_ff;          // half-period counter
  reg        sdi_m_ff;             // data in, first stage
  reg        sdi_s_ff;             // data in, second stage

  reg [3:0]  nxt_state;
  reg [31:0] nxt_rdata;

  wire ext_rise;  // external clock rising edge
  wire ext_fall;  // external clock falling edge

  // external clock pin passes two flops before use
  sbic_edge_sync u_sck_sync (
    .clk    (clk),
    .nrst   (nrst),
    .pin_in (sck_in),
    .level  (),
    .rise   (ext_rise),
    .fall   (ext_fall)
  );

  // divider reload for a code; the half period is one clock longer
  function [DIV_W-1:0] half_period;
    input [2:0] code;
    begin
      half_period = `SBIC_DIV_BASE << code;
    end
  endfunction

  wire sel_en    = wr & (addr == `SBIC_OFF_ENABLE);
  wire sel_xfer  = wr & (addr == `SBIC_OFF_XFER);
  wire sel_data  = wr & (addr == `SBIC_OFF_DATA);
  wire sel_mode  = wr & (addr == `SBIC_OFF_MODE);
  wire use_ext   = (clk_sel_ff == `SBIC_CLK_EXT);  // RL16
  wire sio_mode  = (operating_mode_sel_ff == `SBIC_OPM_SIO);
  // enable gates the engine and all but the enable register; RL2
  wire run       = interface_enable_ff & sio_mode;
  wire do_tx     = (transfer_mode_sel_ff == `SBIC_TM_TX) |
                   (transfer_mode_sel_ff == `SBIC_TM_TXRX);  // RL6
  wire do_rx     = (transfer_mode_sel_ff == `SBIC_TM_RX) |
                   (transfer_mode_sel_ff == `SBIC_TM_TXRX);  // RL6
  wire int_tick  = ~use_ext & (div_ff == {DIV_W{1'b0}});
  // shift and sample moments, internal or external
  wire lead_edge  = use_ext ? ext_fall : (int_tick & sck_ff);   // RL7
  wire trail_edge = use_ext ? ext_rise : (int_tick & ~sck_ff);  // RL7
  wire active    = (state_ff != ST_IDLE);
  wire shifting  = (state_ff == ST_SHIFT);
  // data needed to start a byte: tx needs a buffered byte
  wire byte_ready = ~do_tx | tx_full_ff;
  wire abort     = forced_termination_ff | ~run;  // RL5

  // enable register is always clocked
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      interface_enable_ff <= 1'b0;
    end else if (sel_en) begin
      interface_enable_ff <= wdata[`SBIC_EN_BIT];  // RL1
    end
  end

  // control registers only update while enabled, else they hold
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      transfer_start_ff     <= 1'b0;
      forced_termination_ff <= 1'b0;
      transfer_mode_sel_ff  <= 2'h0;
      clk_sel_ff            <= 3'h0;
      operating_mode_sel_ff <= `SBIC_OPM_RST;
      sio_seen_ff           <= 1'b0;
    end else if (interface_enable_ff) begin  // RL2 RL3
      if (sel_xfer) begin
        transfer_start_ff     <= wdata[`SBIC_START_BIT];  // RL4
        forced_termination_ff <= wdata[`SBIC_TERM_BIT];   // RL5
        transfer_mode_sel_ff  <= wdata[`SBIC_TMODE_HI:`SBIC_TMODE_LO];  // RL6
        clk_sel_ff            <= wdata[`SBIC_CLK_HI:`SBIC_CLK_LO];      // RL7
      end else if (state_ff == ST_WAIT && !transfer_start_ff && !tx_full_ff) begin
        transfer_start_ff     <= 1'b0;
      end
      if (sel_mode) begin
        operating_mode_sel_ff <= wdata[`SBIC_OPM_HI:`SBIC_OPM_LO];  // RL13 RL12
        if (wdata[`SBIC_OPM_HI:`SBIC_OPM_LO] == `SBIC_OPM_SIO) begin
          sio_seen_ff <= 1'b1;  // RL8
        end
      end
    end
  end

  // engine next state
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (run && transfer_start_ff && !forced_termination_ff) begin
          nxt_state = ST_LOAD;  // RL4
        end
      end
      ST_LOAD: begin
        if (abort || !transfer_start_ff) begin
          nxt_state = ST_IDLE;
        end else if (byte_ready) begin
          nxt_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (abort) begin
          nxt_state = ST_IDLE;  // RL5
        end else if (trail_edge && bitcnt_ff == 3'h7) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // stop request lets the last byte finish, then ends
        if (abort || !transfer_start_ff) begin
          nxt_state = ST_IDLE;  // RL4
        end else if (byte_ready) begin
          nxt_state = ST_SHIFT;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // engine datapath; the clock stops while waiting for data
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff  <= ST_IDLE;
      shreg_ff  <= 8'h00;
      bitcnt_ff <= 3'h0;
      sck_ff    <= 1'b1;
      sdo_ff    <= 1'b1;
      irq_ff    <= 1'b0;
      div_ff    <= {DIV_W{1'b0}};
      rx_buf_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      irq_ff   <= 1'b0;
      if (nxt_state == ST_SHIFT && state_ff != ST_SHIFT) begin
        // buffer to shifter in tx modes, zeros in rx mode; buffer now empty; RL17 RL18
        shreg_ff  <= do_tx ? tx_buf_ff : 8'h00;
        irq_ff    <= do_tx;  // RL18
        bitcnt_ff <= 3'h0;
        sck_ff    <= 1'b1;
        div_ff    <= half_period(clk_sel_ff);
      end else if (shifting && !abort) begin
        if (!use_ext) begin
          div_ff <= int_tick ? half_period(clk_sel_ff) : div_ff - 1'b1;
          if (int_tick) begin
            sck_ff <= ~sck_ff;
          end
        end
        if (lead_edge && do_tx) begin
          sdo_ff <= shreg_ff[0];  // RL17 lsb first
        end
        if (trail_edge) begin
          shreg_ff  <= {(do_rx ? sdi_s_ff : 1'b0), shreg_ff[7:1]};
          bitcnt_ff <= bitcnt_ff + 3'h1;
          if (bitcnt_ff == 3'h7 && do_rx) begin
            rx_buf_ff <= {sdi_s_ff, shreg_ff[7:1]};  // RL10
          end
        end
      end else begin
        sck_ff <= 1'b1;
      end
    end
  end

  // transmit side of the buffer and data-in synchroniser
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_buf_ff  <= 8'h00;
      tx_full_ff <= 1'b0;
      sdi_m_ff   <= 1'b0;
      sdi_s_ff   <= 1'b0;
    end else begin
      sdi_m_ff <= sdi;
      sdi_s_ff <= sdi_m_ff;
      if (interface_enable_ff && sel_data) begin
        tx_buf_ff  <= wdata[7:0];  // RL10
        tx_full_ff <= 1'b1;
      end else if (nxt_state == ST_SHIFT && state_ff != ST_SHIFT) begin
        tx_full_ff <= 1'b0;
      end else if (interface_enable_ff && sel_xfer && wdata[`SBIC_TERM_BIT]) begin
        // only the abort write drops a queued byte; a byte written while
        // termination is still set must survive until the start write
        tx_full_ff <= 1'b0;  // RL5
      end
    end
  end

  // read mux; unmapped and constant bits answer fixed values
  always @* begin
    nxt_rdata = 32'h00000000;
    case (addr)
      `SBIC_OFF_ENABLE: begin
        nxt_rdata[`SBIC_EN_BIT] = interface_enable_ff;
      end
      `SBIC_OFF_XFER: begin
        nxt_rdata[`SBIC_START_BIT] = transfer_start_ff;
        nxt_rdata[`SBIC_TERM_BIT]  = forced_termination_ff;
        nxt_rdata[`SBIC_TMODE_HI:`SBIC_TMODE_LO] = transfer_mode_sel_ff;
        nxt_rdata[`SBIC_XFER_ONE_BIT] = 1'b1;  // RL19
        nxt_rdata[`SBIC_CLK_HI:`SBIC_CLK_LO] = clk_sel_ff;
        if (!sio_seen_ff) begin
          nxt_rdata[`SBIC_CLK_LO] = 1'b1;  // RL8
        end
      end
      `SBIC_OFF_DATA: begin
        nxt_rdata[7:0] = rx_buf_ff;  // RL10
      end
      `SBIC_OFF_MODE: begin
        nxt_rdata[7:0] = `SBIC_STAT_ONES;  // RL12 RL19
        nxt_rdata[`SBIC_TACT_BIT] = active;    // RL15
        nxt_rdata[`SBIC_SACT_BIT] = shifting;  // RL15
      end
      default: begin
        nxt_rdata = 32'h00000000;
      end
    endcase
  end

  // read data register, held only the cycle after a strobe
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= rd ? nxt_rdata : 32'h00000000;
    end
  end

  // clock pin driver enable, registered so the pin comes from a flop
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_oe_ff <= 1'b0;
    end else begin
      sck_oe_ff <= interface_enable_ff & ~use_ext;  // RL16
    end
  end

  // outputs straight from flops
  assign rdata            = rdata_ff;
  assign sck_out          = sck_ff;
  assign sck_oe           = sck_oe_ff;  // RL16
  assign sdo              = sdo_ff;
  assign buffer_empty_irq = irq_ff;
endmodule // sbic_top

// *** include/sbic_consts.vh ***
// Purpose: constants for the serial bus interface control block
// Assumes: 32-bit register words, byte addresses on a plain port
// Notes:   offsets are picked for this block, see hand-over
`ifndef SBIC_CONSTS_VH
`define SBIC_CONSTS_VH
// register byte offsets
`define SBIC_OFF_ENABLE   8'h00
`define SBIC_OFF_XFER     8'h04
`define SBIC_OFF_DATA     8'h08
`define SBIC_OFF_MODE     8'h0C
// interface_enable_ctrl fields
`define SBIC_EN_BIT       7
// transfer_ctrl fields
`define SBIC_START_BIT    7
`define SBIC_TERM_BIT     6
`define SBIC_TMODE_HI     5
`define SBIC_TMODE_LO     4
`define SBIC_XFER_ONE_BIT 3
`define SBIC_CLK_HI       2
`define SBIC_CLK_LO       0
// operating_mode_ctrl / status_reg fields
`define SBIC_OPM_HI       3
`define SBIC_OPM_LO       2
`define SBIC_TACT_BIT     3
`define SBIC_SACT_BIT     2
// reset values
`define SBIC_XFER_RST     8'h01
`define SBIC_OPM_RST      2'h0
`define SBIC_STAT_ONES    8'hF3
// codes
`define SBIC_TM_TX        2'h0
`define SBIC_TM_TXRX      2'h2
`define SBIC_TM_RX        2'h3
`define SBIC_OPM_SIO      2'h1
`define SBIC_CLK_EXT      3'h7
// internal clock divider: reload is 2 << code, half period in system clocks is one more
`define SBIC_DIV_BASE     10'h002
`endif

// *** hw/sbic_edge_sync.v ***
// Purpose: two-flop synchroniser with edge detection for the serial clock pin
// Assumes: input is asynchronous to clk
// Notes:   first flop feeds only the second flop
`timescale 1ns/1ns
module sbic_edge_sync (
  input  wire clk,
  input  wire nrst,
  input  wire pin_in,
  output wire level,
  output wire rise,
  output wire fall
);
  reg meta_ff;  // first stage, read only by sync_ff
  reg sync_ff;  // second stage
  reg prev_ff;  // delayed copy for edge finding

  // synchroniser chain and edge history
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise  = sync_ff & ~prev_ff;
  assign fall  = ~sync_ff & prev_ff;
endmodule // sbic_edge_sync

// *** sim/sbic_properties.sv ***
// Purpose: port-level checks of the serial control block
// Assumes: read data stand only in the cycle after the read strobe
// Notes:   sees the top ports only, bound from the bench top
`timescale 1ns/1ns
`include "sbic_consts.vh"
module sbic_properties (
  input wire        clk,
  input wire        nrst,
  input wire [7:0]  addr,
  input wire        rd,
  input wire [31:0] rdata,
  input wire        sck_out,
  input wire        sck_oe,
  input wire        sdo,
  input wire        buffer_empty_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // read cycles of the shared status place and the transfer register
  sequence s_stat_rd;
    rd && addr == `SBIC_OFF_MODE;
  endsequence
  sequence s_xfer_rd;
    rd && addr == `SBIC_OFF_XFER;
  endsequence
  a_irq_single: assert property (buffer_empty_irq |=> !buffer_empty_irq [*8])
    else $error("buffer empty pulse repeated too soon");
  a_rd_idle: assert property (!rd |=> rdata == 32'h0)
    else $error("read data outside a read answer");
  a_stat_const: assert property (s_stat_rd |=> rdata[31:8] == 24'h0 && rdata[7:4] == 4'hF
    && rdata[1:0] == 2'h3)
    else $error("status constant bits wrong");
  a_stat_flags: assert property (s_stat_rd ##1 rdata[2] |-> rdata[3])
    else $error("shift active without transfer active");
  a_xfer_const: assert property (s_xfer_rd |=> rdata[31:8] == 24'h0 && rdata[3])
    else $error("transfer register constant bits wrong");
  a_en_const: assert property (rd && addr == `SBIC_OFF_ENABLE |=>
    rdata[31:8] == 24'h0 && rdata[6:0] == 7'h0)
    else $error("enable register constant bits wrong");
  a_data_upper: assert property (rd && addr == `SBIC_OFF_DATA |=> rdata[31:8] == 24'h0)
    else $error("data buffer upper bits not zero");
  a_sdo_on_fall: assert property (sck_oe && $changed(sdo) |-> !sck_out)
    else $error("serial data moved while clock high");
  a_sck_high_min: assert property (sck_oe && $rose(sck_out) |=> sck_out)
    else $error("serial clock high phase too short");
  a_sck_low_max: assert property (sck_oe && $fell(sck_out) |-> ##[1:260] sck_out)
    else $error("serial clock stuck low");
endmodule // sbic_properties

// *** sim/sbic_peer.sv ***
// Purpose: serial peer on the far side of the shift engine
// Assumes: clock idles high, data lsb first
// Notes:   sends tx_byte back, collects what it hears in rx_byte
`timescale 1ns/1ns
module sbic_peer (
  input  wire       nrst,     // bench reset, clears bit count
  input  wire       sck,      // resolved serial clock pin
  input  wire       sdo,      // data from the block
  input  wire       ext_run,  // request one externally clocked byte
  input  wire [7:0] tx_byte,  // byte sent back to the block
  output reg        ext_clk,  // clock supplied in external mode
  output reg        sdi,      // data to the block
  output reg  [7:0] rx_byte   // last byte heard
);
  reg [2:0] bit_ff;  // bit position in the byte
  initial begin
    ext_clk = 1'b1;
    sdi = 1'b1;
    rx_byte = 8'h00;
  end
  // eight pulses, falling first; clock parks high between frames
  always @(posedge ext_run) begin
    // small offset keeps pin edges off the system clock edges
    #5;
    repeat (8) begin
      #160 ext_clk = 1'b0;
      #160 ext_clk = 1'b1;
    end
  end
  // leading edge: present next bit
  always @(negedge sck) sdi <= tx_byte[bit_ff];
  // trailing edge: take the block's bit, step the count
  always @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      bit_ff <= 3'h0;
    end else begin
      rx_byte[bit_ff] <= sdo;
      bit_ff <= bit_ff + 3'h1;
    end
  end
endmodule // sbic_peer

// *** sim/sbic_top_tb_top.sv ***
// Purpose: self-checking bench for the serial control block
// Assumes: peer model on the serial lines, clock 25 MHz
// Notes:   one byte per transfer, flags polled through status reads
`timescale 1ns/1ns
`include "sbic_consts.vh"
module sbic_top_tb_top;
  reg         clk, nrst, wr, rd, ext_run;
  reg  [7:0]  addr, peer_tx;
  reg  [31:0] wdata, got;
  wire [31:0] rdata;
  wire        sck_out, sck_oe, sdo, sdi, irq, ext_clk;
  wire [7:0]  peer_rx;
  integer     failures, n_compared, irq_n;
  wire        sck = sck_oe ? sck_out : ext_clk;  // resolved pin level
  sbic_top uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sck_in(sck), .sck_out(sck_out), .sck_oe(sck_oe), .sdo(sdo),
    .sdi(sdi), .buffer_empty_irq(irq));
  sbic_peer peer (.nrst(nrst), .sck(sck), .sdo(sdo), .ext_run(ext_run),
    .tx_byte(peer_tx), .ext_clk(ext_clk), .sdi(sdi), .rx_byte(peer_rx));
  // count buffer-empty pulses; each stands one cycle
  always @(posedge clk) if (irq === 1'b1) irq_n <= irq_n + 1;
  task check(input [63:0] nm, input [31:0] s, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("[FAIL] %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  // one-cycle write, then a quiet cycle so strobes never double up
  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd_get(input [7:0] a);
    begin
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 got = rdata;
      @(posedge clk);
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] e);
    begin
      rd_get(a);
      check("rdata", got, e);
    end
  endtask
  // poll status until masked flags match, bounded
  task poll(input [7:0] m, input [7:0] v);
    integer k;
    begin
      k = 0;
      rd_get(`SBIC_OFF_MODE);
      while ((got[7:0] & m) !== v && k < 400) begin
        rd_get(`SBIC_OFF_MODE);
        k = k + 1;
      end
      check("status", {24'h0, got[7:0] & m}, {24'h0, v});
    end
  endtask
  task wrap_up;
    begin
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard, well past the expected run
  initial begin
    #200000;
    failures = failures + 1;
    wrap_up;
  end
  initial begin
    {nrst, wr, rd, ext_run, addr, wdata} = 44'h0;
    peer_tx = 8'h3C;
    failures = 0;
    n_compared = 0;
    irq_n = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_chk(`SBIC_OFF_ENABLE, 32'h0);
    rd_chk(`SBIC_OFF_XFER, 32'h09);
    rd_chk(`SBIC_OFF_DATA, 32'h0);
    rd_chk(`SBIC_OFF_MODE, 32'hF3);
    wr_reg(`SBIC_OFF_XFER, 32'h62);
    rd_chk(`SBIC_OFF_XFER, 32'h09);
    wr_reg(`SBIC_OFF_ENABLE, 32'hFFFFFFFF);
    rd_chk(`SBIC_OFF_ENABLE, 32'h80);
    wr_reg(`SBIC_OFF_MODE, 32'h04);
    rd_chk(`SBIC_OFF_XFER, 32'h08);
    rd_chk(`SBIC_OFF_MODE, 32'hF3);
    // transmit/receive byte on the internal clock
    wr_reg(`SBIC_OFF_XFER, 32'h60);
    rd_chk(`SBIC_OFF_XFER, 32'h68);
    #1 check("sck_oe", {31'h0, sck_oe}, 32'h1);
    @(posedge clk);
    wr_reg(`SBIC_OFF_DATA, 32'hA5);
    rd_chk(`SBIC_OFF_DATA, 32'h0);
    wr_reg(`SBIC_OFF_XFER, 32'hA0);
    poll(8'h04, 8'h04);
    check("irq", irq_n, 32'h1);
    wr_reg(`SBIC_OFF_XFER, 32'h20);
    poll(8'h0C, 8'h00);
    check("peer_rx", {24'h0, peer_rx}, 32'hA5);
    rd_chk(`SBIC_OFF_DATA, 32'h3C);
    // transmit byte on the peer's clock
    wr_reg(`SBIC_OFF_XFER, 32'h47);
    rd_chk(`SBIC_OFF_XFER, 32'h4F);
    #1 check("sck_oe", {31'h0, sck_oe}, 32'h0);
    @(posedge clk);
    wr_reg(`SBIC_OFF_DATA, 32'h5A);
    wr_reg(`SBIC_OFF_XFER, 32'h87);
    poll(8'h04, 8'h04);
    check("irq", irq_n, 32'h2);
    wr_reg(`SBIC_OFF_XFER, 32'h07);
    ext_run <= 1'b1;
    @(posedge clk);
    ext_run <= 1'b0;
    poll(8'h0C, 8'h00);
    check("peer_rx", {24'h0, peer_rx}, 32'h5A);
    // receive byte aborted mid-shift
    wr_reg(`SBIC_OFF_XFER, 32'h70);
    wr_reg(`SBIC_OFF_XFER, 32'hB0);
    poll(8'h04, 8'h04);
    wr_reg(`SBIC_OFF_XFER, 32'h70);
    rd_chk(`SBIC_OFF_MODE, 32'hF3);
    // disable keeps settings and refuses writes
    wr_reg(`SBIC_OFF_ENABLE, 32'h0);
    wr_reg(`SBIC_OFF_XFER, 32'h01);
    wr_reg(`SBIC_OFF_ENABLE, 32'h80);
    rd_chk(`SBIC_OFF_XFER, 32'h78);
    wrap_up;
  end
endmodule // sbic_top_tb_top
bind sbic_top sbic_properties u_props (.clk(clk), .nrst(nrst), .addr(addr), .rd(rd),
  .rdata(rdata), .sck_out(sck_out), .sck_oe(sck_oe), .sdo(sdo),
  .buffer_empty_irq(buffer_empty_irq));
